// file: hdl/afsc_regs.svh
// Timing constants and rule summary for the amplifier failover controller
//
// Summary of operation
// R1: Steady for first supply, slow for second
// R2: Supply fault indication latches until restart
// R3: Lost source power counts as supply fault
// R4: Operator restarts after supply restore or install
// R5: Relay energised healthy, released on failure
// R6: Alarm on changeover, supply or amp fault
// R7: Warning steady when using stored references
// R8: Warning slow until references are captured
// R9: Warning fast while forced to backup; here not once in AFSC_ON_BACKUP after changeover
// R10: Failure steady after changeover to backup
// R11: Failure slow when backup alone failed
// R12: Failure fast on low input or both
// R13: Restart returns controller to initial state
// R14: Capture stores levels and starts monitoring
// R15: Force button selects backup while held
// R16: Primary selected after power-up or restart
// R17: Primary down, backup fine: switch, alarm, stay
// R18: Backup down with primary active: judged failed
// R19: Three minute wait, then stored references
// R20: Blink patterns from clock counters, half duty
`ifndef AFSC_REGS_SVH
`define AFSC_REGS_SVH
// ****************************************
// Timing
// ****************************************
`define AFSC_CLK_HZ 10000000
`define AFSC_SLOW_HZ 1
`define AFSC_FAST_HZ 3
`define AFSC_WAIT_MIN 3
`define AFSC_WAIT_CYC (`AFSC_WAIT_MIN * 60 * `AFSC_CLK_HZ)
`define AFSC_SLOW_HALF (`AFSC_CLK_HZ / (2 * `AFSC_SLOW_HZ))
`define AFSC_FAST_HALF (`AFSC_CLK_HZ / (2 * `AFSC_FAST_HZ))
// Level drop threshold, in detector code units
`define AFSC_DROP_CODE 8'h1E
`endif

// file: hdl/afsc_pkg.sv
// Types shared by the amplifier failover controller
`default_nettype none
package afsc_pkg;
    // Controller phases
    typedef enum logic [2:0] {
        AFSC_WAIT_REF,
        AFSC_MONITOR,
        AFSC_ON_BACKUP,
        AFSC_BACKUP_BAD,
        AFSC_INPUT_LOW
    } afsc_state_t;
    // Lamp patterns
    typedef enum logic [1:0] {
        AFSC_OFF,
        AFSC_STEADY,
        AFSC_SLOW,
        AFSC_FAST
    } afsc_lamp_t;
endpackage
`default_nettype wire

// file: hdl/afsc_blink.sv
// Half-duty blink generator for one rate
`default_nettype none
module afsc_blink #(
    parameter int unsigned HALF = 5000000
) (
    input wire logic core_clk,
    input wire logic reset,
    output logic blink
);
    // Cycle count within one half period
    logic [31:0] cnt_q;

    // ****************************************
    // Half-period counter
    // ****************************************
    // R20: half on, half off
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cnt_q <= 32'h0000_0000;
            blink <= 1'b0;
        end
        else if (cnt_q >= HALF - 1)
        begin
            cnt_q <= 32'h0000_0000;
            blink <= ~blink;
        end
        else
        begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

// file: hdl/afsc_top.sv
// Amplifier failover controller: path select, lamps and alarm relay
`include "afsc_regs.svh"
`default_nettype none
module afsc_top
    import afsc_pkg::*;
#(
    parameter int unsigned WAIT_CYC = `AFSC_WAIT_CYC,
    parameter int unsigned SLOW_HALF = `AFSC_SLOW_HALF,
    parameter int unsigned FAST_HALF = `AFSC_FAST_HALF,
    parameter logic [7:0] DROP = `AFSC_DROP_CODE
) (
    input wire logic core_clk,
    // Restart button, also the reset
    input wire logic reset,
    // Supplies good (source power present and supply healthy)
    input wire logic first_supply_ok,
    input wire logic second_supply_ok,
    // Sampled amplifier output levels
    input wire logic [7:0] primary_level,
    input wire logic [7:0] backup_level,
    // Stored references from nonvolatile memory
    input wire logic [7:0] stored_primary_ref,
    input wire logic [7:0] stored_backup_ref,
    // Operator buttons, high while pressed
    input wire logic capture_ref_button,
    input wire logic force_backup_button,
    // Output path: 1 selects backup amplifier
    output logic select_backup,
    // Lamps
    output logic supply_fault_indicator,
    output logic warning_indicator,
    output logic failure_indicator,
    // Relay energised: common tied to normally open
    output logic relay_energised,
    // References came from storage
    output logic using_stored_ref
);
    // ****************************************
    // Declarations
    // ****************************************
    afsc_state_t state_q; // Controller phase
    logic [7:0] pri_ref_q; // Primary reference level
    logic [7:0] bak_ref_q; // Backup reference level
    logic stored_q; // References were loaded from storage
    logic [31:0] wait_q; // Reference wait counter
    logic sup1_lat_q; // First supply fault seen
    logic sup2_lat_q; // Second supply fault seen
    logic slow_blink; // 1 per second
    logic fast_blink; // 3 per second
    logic pri_down; // Primary dropped past threshold
    logic bak_down; // Backup dropped past threshold
    logic fail_any; // Any failure condition
    afsc_lamp_t warn_mode; // Warning lamp pattern
    afsc_lamp_t fail_mode; // Failure lamp pattern

    // Drop test: reference minus level at or past threshold
    function automatic logic dropped(input logic [7:0] lvl,
                                     input logic [7:0] ref_lvl);
        dropped = ({1'b0, lvl} + {1'b0, DROP}) <= {1'b0, ref_lvl};
    endfunction

    // Lamp pattern decode, shared by the warning and failure lamps
    function automatic logic lamp(input afsc_lamp_t m, input logic s,
                                  input logic f);
        case (m)
            AFSC_STEADY: lamp = 1'b1;
            AFSC_SLOW: lamp = s;
            AFSC_FAST: lamp = f;
            default: lamp = 1'b0;
        endcase
    endfunction

    // ****************************************
    // Blink generators
    // ****************************************
    afsc_blink #(.HALF(SLOW_HALF)) u_slow (
        .core_clk(core_clk),
        .reset(reset),
        .blink(slow_blink)
    );
    afsc_blink #(.HALF(FAST_HALF)) u_fast (
        .core_clk(core_clk),
        .reset(reset),
        .blink(fast_blink)
    );

    assign pri_down = dropped(primary_level, pri_ref_q);
    assign bak_down = dropped(backup_level, bak_ref_q);

    // ****************************************
    // Supply fault latches
    // ****************************************
    // R2: latched until restart
    always_ff @(posedge core_clk)
    begin
        // R13: restart clears everything
        if (reset)
        begin
            sup1_lat_q <= 1'b0;
            sup2_lat_q <= 1'b0;
        end
        else
        begin
            // R3: lost source power is a fault
            if (!first_supply_ok)
                sup1_lat_q <= 1'b1;
            if (!second_supply_ok)
                sup2_lat_q <= 1'b1;
        end
    end

    // ****************************************
    // Reference wait counter
    // ****************************************
    // R19: three minute wait for capture
    always_ff @(posedge core_clk)
    begin
        if (reset || state_q != AFSC_WAIT_REF)
            wait_q <= 32'h0000_0000;
        else if (wait_q < WAIT_CYC)
            wait_q <= wait_q + 32'h0000_0001;
    end

    // ****************************************
    // Reference registers
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            pri_ref_q <= 8'h00;
            bak_ref_q <= 8'h00;
            stored_q <= 1'b0;
        end
        else if (state_q == AFSC_WAIT_REF)
        begin
            // R14: capture present levels
            if (capture_ref_button)
            begin
                pri_ref_q <= primary_level;
                bak_ref_q <= backup_level;
                stored_q <= 1'b0;
            end
            // R19: fall back to stored values
            else if (wait_q >= WAIT_CYC - 1)
            begin
                pri_ref_q <= stored_primary_ref;
                bak_ref_q <= stored_backup_ref;
                stored_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // Controller phase
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        // R16: start on primary path
        if (reset)
            state_q <= AFSC_WAIT_REF;
        else
        begin
            case (state_q)
                AFSC_WAIT_REF:
                begin
                    if (capture_ref_button || wait_q >= WAIT_CYC - 1)
                        state_q <= AFSC_MONITOR;
                end
                AFSC_MONITOR:
                begin
                    // Forced path blinds the detectors
                    if (force_backup_button)
                        state_q <= AFSC_MONITOR;
                    // R12: both down means low input
                    else if (pri_down && bak_down)
                        state_q <= AFSC_INPUT_LOW;
                    // R17: switch over for good
                    else if (pri_down)
                        state_q <= AFSC_ON_BACKUP;
                    // R18: backup judged failed
                    else if (bak_down)
                        state_q <= AFSC_BACKUP_BAD;
                end
                AFSC_BACKUP_BAD:
                begin
                    // Primary loss now leaves no good amplifier
                    if (pri_down && !force_backup_button)
                        state_q <= AFSC_INPUT_LOW;
                end
                // Terminal until restart; no further switch
                AFSC_ON_BACKUP: state_q <= AFSC_ON_BACKUP;
                AFSC_INPUT_LOW: state_q <= AFSC_INPUT_LOW;
                default: state_q <= AFSC_WAIT_REF;
            endcase
        end
    end

    // ****************************************
    // Lamp pattern selection
    // ****************************************
    always_comb
    begin
        // R9: fast while forced to backup, except in AFSC_ON_BACKUP after changeover
        if (force_backup_button && state_q != AFSC_ON_BACKUP)
            warn_mode = AFSC_FAST;
        // R8: request reference capture
        else if (state_q == AFSC_WAIT_REF)
            warn_mode = AFSC_SLOW;
        // R7: stored references in use
        else if (stored_q)
            warn_mode = AFSC_STEADY;
        else
            warn_mode = AFSC_OFF;
        case (state_q)
            // R10: changed over to backup
            AFSC_ON_BACKUP: fail_mode = AFSC_STEADY;
            // R11: backup alone failed
            AFSC_BACKUP_BAD: fail_mode = AFSC_SLOW;
            // R12: low input or both failed
            AFSC_INPUT_LOW: fail_mode = AFSC_FAST;
            default: fail_mode = AFSC_OFF;
        endcase
    end

    // R6: any failure raises alarm
    assign fail_any = sup1_lat_q || sup2_lat_q ||
                      state_q == AFSC_ON_BACKUP ||
                      state_q == AFSC_BACKUP_BAD ||
                      state_q == AFSC_INPUT_LOW;

    // ****************************************
    // Registered outputs
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            select_backup <= 1'b0;
            supply_fault_indicator <= 1'b0;
            warning_indicator <= 1'b0;
            failure_indicator <= 1'b0;
            relay_energised <= 1'b0;
            using_stored_ref <= 1'b0;
        end
        else
        begin
            // R15: held button picks backup
            select_backup <= force_backup_button ||
                             state_q == AFSC_ON_BACKUP;
            // R1: steady first, slow second
            supply_fault_indicator <= sup1_lat_q ? 1'b1 :
                                      (sup2_lat_q & slow_blink);
            warning_indicator <= lamp(warn_mode, slow_blink, fast_blink);
            failure_indicator <= lamp(fail_mode, slow_blink, fast_blink);
            // R5: energised while healthy
            relay_energised <= !fail_any;
            using_stored_ref <= stored_q;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_relay_drop: assert property (@(posedge core_clk) disable iff (reset)
        fail_any |=> !relay_energised) // R5
        else $error("relay stays energised on failure");
    a_supply_latch: assert property (@(posedge core_clk) disable iff (reset)
        sup1_lat_q |=> sup1_lat_q && !relay_energised) // R2
        else $error("supply fault latch lost");
    a_first_steady: assert property (@(posedge core_clk) disable iff (reset)
        sup1_lat_q |=> supply_fault_indicator) // R1
        else $error("supply lamp not steady");
    a_fault_set: assert property (@(posedge core_clk) disable iff (reset)
        !second_supply_ok |=> sup2_lat_q) // R3
        else $error("lost supply not latched");
    a_no_reswitch: assert property (@(posedge core_clk) disable iff (reset)
        state_q == AFSC_ON_BACKUP |=> select_backup [*2]) // R17
        else $error("path left backup after changeover");
    a_primary_start: assert property (@(posedge core_clk)
        $fell(reset) && !force_backup_button |-> !select_backup) // R16
        else $error("backup selected after restart");
    a_force_path: assert property (@(posedge core_clk) disable iff (reset)
        force_backup_button |=> select_backup) // R15
        else $error("force button ignored");
    a_capture_ref: assert property (@(posedge core_clk) disable iff (reset)
        state_q == AFSC_WAIT_REF && capture_ref_button
        |=> pri_ref_q == $past(primary_level) && !stored_q) // R14
        else $error("reference not captured");
    a_fail_steady: assert property (@(posedge core_clk) disable iff (reset)
        state_q == AFSC_ON_BACKUP ##1 state_q == AFSC_ON_BACKUP
        |-> failure_indicator) // R10
        else $error("failure lamp not steady");
    a_backup_bad: assert property (@(posedge core_clk) disable iff (reset)
        state_q == AFSC_MONITOR && !force_backup_button && bak_down
        && !pri_down |=> state_q == AFSC_BACKUP_BAD) // R18
        else $error("backup failure missed");

    c_changeover: cover property (@(posedge core_clk)
        state_q == AFSC_MONITOR ##1 state_q == AFSC_ON_BACKUP);
    c_input_low: cover property (@(posedge core_clk)
        state_q == AFSC_INPUT_LOW);
    c_stored: cover property (@(posedge core_clk) $rose(stored_q));
endmodule
`default_nettype wire

// file: bench/afsc_panel_model.sv
// Operator buttons and alarm monitor facing the controller
`default_nettype none
module afsc_panel_model (
    input wire logic core_clk,
    input wire logic want_restart,
    input wire logic want_capture,
    input wire logic want_force,
    input wire logic relay_energised,
    output var logic reset,
    output var logic capture_ref_button,
    output var logic force_backup_button,
    output logic alarm_nc_closed
);
    timeunit 1ns;
    timeprecision 1ns;
    // operator restart press
    // Restart held from power-up until the bench lets go; one process
    // owns each button so no pin has two drivers
    // Buttons move only just after an edge, like a debounced panel
    initial
    begin
        reset = 1'b1;
        capture_ref_button = 1'b0;
        force_backup_button = 1'b0;
        forever
        begin
            @(posedge core_clk);
            reset <= want_restart;
            capture_ref_button <= want_capture;
            force_backup_button <= want_force;
        end
    end
    // form-C contact view
    // Monitor sees the NC side closed whenever the coil drops
    assign alarm_nc_closed = !relay_energised;
endmodule
`default_nettype wire

// file: bench/tb_afsc_top.sv
// Self-checking bench for the amplifier failover controller
`default_nettype none
module tb_afsc_top import afsc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Signals
    // ****
    logic core_clk = 1'b0;
    logic want_restart = 1'b1;
    logic want_capture = 1'b0;
    logic want_force = 1'b0;
    logic first_ok = 1'b1;
    logic second_ok = 1'b1;
    logic [7:0] p_lvl = 8'h80;
    logic [7:0] b_lvl = 8'h80;
    // Stored references differ from captured levels so their use shows
    logic [7:0] st_p = 8'h90;
    logic [7:0] st_b = 8'h70;
    logic reset, cap_btn, frc_btn, alarm_nc;
    logic select_backup, sup_ind, warn_ind, fail_ind, relay, stored;
    int fail_count = 0;
    int cmp_count = 0;
    // 10 MHz clock
    always #50 core_clk = ~core_clk;
    // Short counts keep the run small; expectations follow them
    // Wait outlasts the opening lamp checks so capture still lands
    afsc_top #(.WAIT_CYC(100), .SLOW_HALF(4), .FAST_HALF(2),
        .DROP(8'h1E)) DUT (
        .core_clk(core_clk),
        .reset(reset),
        .first_supply_ok(first_ok),
        .second_supply_ok(second_ok),
        .primary_level(p_lvl),
        .backup_level(b_lvl),
        .stored_primary_ref(st_p),
        .stored_backup_ref(st_b),
        .capture_ref_button(cap_btn),
        .force_backup_button(frc_btn),
        .select_backup(select_backup),
        .supply_fault_indicator(sup_ind),
        .warning_indicator(warn_ind),
        .failure_indicator(fail_ind),
        .relay_energised(relay),
        .using_stored_ref(stored)
    );
    afsc_panel_model panel (
        .core_clk(core_clk),
        .want_restart(want_restart),
        .want_capture(want_capture),
        .want_force(want_force),
        .relay_energised(relay),
        .reset(reset),
        .capture_ref_button(cap_btn),
        .force_backup_button(frc_btn),
        .alarm_nc_closed(alarm_nc)
    );
    // ****
    // Tasks
    // ****
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input logic got, input logic exp, input string m);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: %s", $time, m);
        end
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return sup_ind;
            1: return warn_ind;
            default: return fail_ind;
        endcase
    endfunction
    // Classify a lamp over 24 cycles by on-count and edge count
    // Fast blink changes about every 2 cycles, slow every 4
    task automatic lamp(input int w, input afsc_lamp_t exp, input string m);
        int hi;
        int ch;
        logic v;
        logic p;
        afsc_lamp_t got;
        hi = 0;
        ch = 0;
        p = pick(w);
        repeat (24)
        begin
            @(posedge core_clk);
            #1;
            v = pick(w);
            hi += int'(v === 1'b1);
            ch += int'(v !== p);
            p = v;
        end
        if (hi == 0)
            got = AFSC_OFF;
        else if (hi == 24)
            got = AFSC_STEADY;
        else
            got = (ch >= 9) ? AFSC_FAST : AFSC_SLOW;
        // Blinks must be near half duty
        chk((got == exp) && (hi == 0 || hi == 24 || (hi >= 10 && hi <= 14)),
            1'b1, m);
    endtask
    // Hold restart for 10 cycles, then let it go
    // The panel adds one cycle, so the request drops one edge early
    task automatic restart();
        @(posedge core_clk);
        want_restart <= 1'b1;
        cyc(10);
        want_restart <= 1'b0;
        cyc(3);
        #1;
    endtask
    task automatic capture();
        @(posedge core_clk);
        want_capture <= 1'b1;
        cyc(2);
        want_capture <= 1'b0;
        cyc(3);
        #1;
    endtask
    task automatic force_btn(input logic on);
        @(posedge core_clk);
        want_force <= on;
        cyc(3);
        #1;
    endtask
    // Levels and supplies; answers land within two cycles
    task automatic apply(input logic [7:0] p, input logic [7:0] b,
        input logic s1, input logic s2);
        @(posedge core_clk);
        p_lvl <= p;
        b_lvl <= b;
        first_ok <= s1;
        second_ok <= s2;
        cyc(4);
        #1;
    endtask
    task automatic done(input string n);
        $display("Test %s finished, %0d mismatches", n, fail_count);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ****
    // Tests
    // ****
    initial
    begin
        restart();
        chk(select_backup, 1'b0, "primary after restart");
        chk(stored, 1'b0, "no stored refs yet");
        lamp(1, AFSC_SLOW, "warn slow before capture");
        lamp(2, AFSC_OFF, "failure off at start");
        capture();
        lamp(1, AFSC_OFF, "warn off after capture");
        chk(alarm_nc, 1'b0, "relay healthy");
        force_btn(1'b1);
        chk(select_backup, 1'b1, "forced to backup");
        lamp(1, AFSC_FAST, "warn fast while forced");
        force_btn(1'b0);
        chk(select_backup, 1'b0, "back on primary");
        // One code short of the drop threshold: no action
        apply(8'h80, 8'h63, 1'b1, 1'b1);
        lamp(2, AFSC_OFF, "no fault above threshold");
        apply(8'h80, 8'h62, 1'b1, 1'b1);
        lamp(2, AFSC_SLOW, "backup judged failed");
        chk(alarm_nc, 1'b1, "alarm on backup fault");
        apply(8'h62, 8'h62, 1'b1, 1'b1);
        lamp(2, AFSC_FAST, "escalate to input low");
        done("backup_fault");
        apply(8'h80, 8'h80, 1'b1, 1'b1);
        restart();
        capture();
        apply(8'h62, 8'h80, 1'b1, 1'b1);
        chk(select_backup, 1'b1, "changeover to backup");
        lamp(2, AFSC_STEADY, "failure steady");
        chk(alarm_nc, 1'b1, "alarm on changeover");
        apply(8'h80, 8'h62, 1'b1, 1'b1);
        chk(select_backup, 1'b1, "no further switch");
        lamp(2, AFSC_STEADY, "changeover holds");
        done("changeover");
        apply(8'h80, 8'h80, 1'b1, 1'b1);
        restart();
        capture();
        apply(8'h62, 8'h62, 1'b1, 1'b1);
        lamp(2, AFSC_FAST, "both low at once");
        chk(alarm_nc, 1'b1, "alarm on input low");
        done("input_low");
        apply(8'h80, 8'h80, 1'b1, 1'b1);
        restart();
        cyc(110);
        #1;
        chk(stored, 1'b1, "stored refs after wait");
        lamp(1, AFSC_STEADY, "warn steady on stored");
        // Drop against the stored primary value, not the live level
        apply(8'h72, 8'h80, 1'b1, 1'b1);
        chk(select_backup, 1'b1, "stored primary ref in use");
        done("stored_refs");
        restart();
        capture();
        apply(8'h80, 8'h80, 1'b1, 1'b0);
        lamp(0, AFSC_SLOW, "second supply fault");
        chk(alarm_nc, 1'b1, "alarm on supply loss");
        apply(8'h80, 8'h80, 1'b1, 1'b1);
        lamp(0, AFSC_SLOW, "supply fault latched");
        restart();
        lamp(0, AFSC_OFF, "restart clears latch");
        apply(8'h80, 8'h80, 1'b0, 1'b1);
        lamp(0, AFSC_STEADY, "first supply fault");
        done("supplies");
        end_of_test();
    end
    // Watchdog: the tests need well under 2000 cycles
    initial
    begin
        cyc(20000);
        fail_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
